/* pkg/aft_pkg.sv */
// Shared constants and types for the port flow-control and status link.
`default_nettype none
package aft_pkg;
  // Status bus width and encodings; ST_FRAME_OK is the one that has meaning in frame mode.
  localparam int          ST_W          = 3;
  localparam logic [2:0]  ST_FRAME_OK   = 3'h7;
  localparam logic [2:0]  ST_IDLE       = 3'h0;
  localparam logic [2:0]  ST_READ_LP    = 3'h1;
  localparam logic [2:0]  ST_FAST_WRITE = 3'h2;
  // Length of one data transfer on the link, in clock cycles.
  localparam int          XFER_LEN      = 4;
  localparam logic [1:0]  XFER_LAST     = 2'h3;
  // Values after reset.
  localparam logic        FLAG_RST      = 1'b1;
  typedef enum logic [1:0] {AFT_MODE_PIPE, AFT_MODE_SBA, AFT_MODE_FRAME} aft_mode_t;
endpackage
`default_nettype wire

/* pkg/aft_link_if.sv */
// Link between the port target/arbiter and the graphics master.
`timescale 1ns/1ps
`default_nettype none
interface aft_link_if;
  logic       rbf_n;
  logic       wbf_n;
  logic [2:0] st;
  logic       gnt_n;
  logic       data_valid;
  logic [31:0] data;
  modport target (input rbf_n, input wbf_n, output st, output gnt_n,
                  output data_valid, output data);
  modport master (output rbf_n, output wbf_n, input st, input gnt_n,
                  input data_valid, input data);
endinterface
`default_nettype wire

/* hw/aft_target.sv */
// Target and arbiter end: full-flag flow control and status bus drive.
//
// Functional notes
// - Read-full held off new low-priority returns.
// - Return already in progress may finish.
// - Read-full judged only at return start.
// - Absent read-full means always deasserted.
// - Write-full blocks fast-write data drive.
// - Write-full judged only at write start.
// - Absent write-full means always deasserted.
// - Frame mode ignores both full flags.
// - Arbiter drives three-bit status bus.
// - Master reads status only under grant.
// - Master ignores status without grant.
// - Frame mode: status 111 permits frame.
// - Enqueue mode static until system reset.
`timescale 1ns/1ps
`default_nettype none
module aft_target (
  // Clock and reset
  input  wire logic            core_clk,
  input  wire logic            rst_n,
  // Link
  aft_link_if.target           link,
  // User side
  input  wire aft_pkg::aft_mode_t mode,
  input  wire logic            rd_req,
  input  wire logic [31:0]     rd_data,
  input  wire logic            fw_req,
  input  wire logic [31:0]     fw_data,
  input  wire logic            frame_req,
  output logic                 rd_ack,
  output logic                 fw_ack,
  output logic                 busy
);
  // ****************************************
  // Flag synchronisers
  // ****************************************
  logic [1:0] rbf_sync_reg;
  logic [1:0] wbf_sync_reg;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rbf_sync_reg <= {2{aft_pkg::FLAG_RST}};
      wbf_sync_reg <= {2{aft_pkg::FLAG_RST}};
    end else begin
      rbf_sync_reg <= {rbf_sync_reg[0], link.rbf_n};
      wbf_sync_reg <= {wbf_sync_reg[0], link.wbf_n};
    end
  end
  // unused flag pulled high, reads as not full
  wire rd_full = ~rbf_sync_reg[1];
  wire wr_full = ~wbf_sync_reg[1];
  // ****************************************
  // Transfer sequencing
  // ****************************************
  typedef enum logic [1:0] {AFT_IDLE, AFT_READ, AFT_WRITE, AFT_FRAME} aft_state_t;
  aft_state_t state_reg;
  aft_state_t state_next;
  logic [1:0] beat_reg;
  logic [2:0] st_reg;
  logic       gnt_n_reg;
  logic       dv_reg;
  logic [31:0] data_reg;
  logic       rd_ack_reg;
  logic       fw_ack_reg;
  logic       busy_reg;
  // flags only count outside frame mode
  wire frame_mode = (mode == aft_pkg::AFT_MODE_FRAME);
  // read start only when not full at start
  wire rd_go = rd_req && (frame_mode || !rd_full);
  // write start only when not full at start
  wire fw_go = fw_req && (frame_mode || !wr_full);
  wire last  = (beat_reg == aft_pkg::XFER_LAST);
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      AFT_IDLE: begin
        if (frame_mode && frame_req) begin
          state_next = AFT_FRAME;
        end else if (!frame_mode && rd_go) begin
          state_next = AFT_READ;
        end else if (!frame_mode && fw_go) begin
          state_next = AFT_WRITE;
        end
      end
      // running return ends regardless of flag
      AFT_READ, AFT_WRITE: begin
        if (last) begin
          state_next = AFT_IDLE;
        end
      end
      AFT_FRAME: begin
        if (!frame_req) begin
          state_next = AFT_IDLE;
        end
      end
    endcase
  end
  wire [2:0] st_next = (state_next == AFT_READ)  ? aft_pkg::ST_READ_LP :
                       (state_next == AFT_WRITE) ? aft_pkg::ST_FAST_WRITE :
                       (state_next == AFT_FRAME) ? aft_pkg::ST_FRAME_OK :
                       aft_pkg::ST_IDLE;
  // ****************************************
  // Decoded strobes
  // ****************************************
  wire        start_rd   = (state_reg == AFT_IDLE) && (state_next == AFT_READ);
  wire        start_fw   = (state_reg == AFT_IDLE) && (state_next == AFT_WRITE);
  wire        in_data    = (state_next == AFT_READ) || (state_next == AFT_WRITE);
  wire        beat_stay  = (state_reg == state_next) && in_data;
  // beat count runs out whatever the flag does
  wire [1:0]  beat_next  = beat_stay ? (beat_reg + 2'h1) : 2'h0;
  wire        gnt_n_next = (state_next == AFT_IDLE);
  wire [31:0] data_next  = (state_next == AFT_WRITE) ? fw_data :
                           (state_next == AFT_READ)  ? rd_data : 32'h0;
  // ****************************************
  // State and beat counter
  // ****************************************
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= AFT_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      beat_reg <= 2'h0;
    end else begin
      beat_reg <= beat_next;
    end
  end
  // ****************************************
  // Status bus and grant
  // ****************************************
  // registered status
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= aft_pkg::ST_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      gnt_n_reg <= 1'b1;
    end else begin
      gnt_n_reg <= gnt_n_next;
    end
  end
  // The busy output mirrors the grant but has its own flop so it stays glitch free.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_reg <= 1'b0;
    end else begin
      busy_reg <= ~gnt_n_next;
    end
  end
  // ****************************************
  // Data beats
  // ****************************************
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      dv_reg <= 1'b0;
    end else begin
      dv_reg <= in_data;
    end
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      data_reg <= 32'h0;
    end else begin
      data_reg <= data_next;
    end
  end
  // ****************************************
  // User acknowledges
  // ****************************************
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_ack_reg <= 1'b0;
    end else begin
      rd_ack_reg <= start_rd;
    end
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      fw_ack_reg <= 1'b0;
    end else begin
      fw_ack_reg <= start_fw;
    end
  end
  // ****************************************
  // Outputs
  // ****************************************
  assign link.st         = st_reg;
  assign link.gnt_n      = gnt_n_reg;
  assign link.data_valid = dv_reg;
  assign link.data       = data_reg;
  assign rd_ack          = rd_ack_reg;
  assign fw_ack          = fw_ack_reg;
  assign busy            = busy_reg;
endmodule
`default_nettype wire

/* hw/aft_master.sv */
// Graphics master end: drives full flags, decodes granted status.
`timescale 1ns/1ps
`default_nettype none
module aft_master (
  // Clock and reset
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  // Link
  aft_link_if.master        link,
  // User side
  input  wire logic         rd_full,
  input  wire logic         wr_full,
  output logic              rd_beat,
  output logic              fw_beat,
  output logic              frame_ok,
  output logic [31:0]       beat_data
);
  logic rbf_n_reg;
  logic wbf_n_reg;
  logic rd_beat_reg;
  logic fw_beat_reg;
  logic frame_ok_reg;
  logic [31:0] data_reg;
  wire granted = ~link.gnt_n;
  wire is_rd   = granted && link.data_valid && (link.st == aft_pkg::ST_READ_LP);
  wire is_fw   = granted && link.data_valid && (link.st == aft_pkg::ST_FAST_WRITE);
  wire is_fr   = granted && (link.st == aft_pkg::ST_FRAME_OK);
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rbf_n_reg    <= aft_pkg::FLAG_RST;
      wbf_n_reg    <= aft_pkg::FLAG_RST;
      rd_beat_reg  <= 1'b0;
      fw_beat_reg  <= 1'b0;
      frame_ok_reg <= 1'b0;
      data_reg     <= 32'h0;
    end else begin
      rbf_n_reg    <= ~rd_full;
      wbf_n_reg    <= ~wr_full;
      rd_beat_reg  <= is_rd;
      fw_beat_reg  <= is_fw;
      frame_ok_reg <= is_fr;
      data_reg     <= link.data;
    end
  end
  assign link.rbf_n = rbf_n_reg;
  assign link.wbf_n = wbf_n_reg;
  assign rd_beat    = rd_beat_reg;
  assign fw_beat    = fw_beat_reg;
  assign frame_ok   = frame_ok_reg;
  assign beat_data  = data_reg;
endmodule
`default_nettype wire

/* verification/aft_link_properties.sv */
// Checker for status and flow-control behaviour on the link.
`timescale 1ns/1ps
`default_nettype none
module aft_link_properties (
  // Clock and reset
  input wire logic       core_clk,
  input wire logic       rst_n,
  // Link
  input wire logic       rbf_n,
  input wire logic       wbf_n,
  input wire logic [2:0] st,
  input wire logic       gnt_n,
  input wire logic       data_valid
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence s_rd; $fell(gnt_n) && st == aft_pkg::ST_READ_LP; endsequence
  sequence s_fw; $fell(gnt_n) && st == aft_pkg::ST_FAST_WRITE; endsequence
  a_idle_status: assert property (gnt_n |-> st == aft_pkg::ST_IDLE && !data_valid)
    else $error("status not idle without grant");
  a_valid_granted: assert property (data_valid |-> !gnt_n)
    else $error("data beat without grant");
  a_status_steady: assert property (!gnt_n && $past(!gnt_n) |-> $stable(st))
    else $error("status changed inside a grant");
  a_rd_beats: assert property (s_rd |-> (data_valid && !gnt_n)[*4] ##1 gnt_n)
    else $error("read return not four beats");
  a_fw_beats: assert property (s_fw |-> (data_valid && !gnt_n)[*4] ##1 gnt_n)
    else $error("fast write not four beats");
  // Five low samples cover the two-flop sampling delay of the flag.
  a_rd_full_hold: assert property ((!rbf_n)[*5] |=> not s_rd)
    else $error("read return began while read full");
  a_wr_full_hold: assert property ((!wbf_n)[*5] |=> not s_fw)
    else $error("fast write began while write full");
  a_frame_code: assert property (!gnt_n && !data_valid |-> st == aft_pkg::ST_FRAME_OK)
    else $error("frame grant without frame status");
endmodule
`default_nettype wire

/* verification/testbench.sv */
// Bench joining target and master ends across one link.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic core_clk = 0, rst_n = 0, rd_req = 0, fw_req = 0, frame_req = 0;
  logic rd_full = 0, wr_full = 0, rd_ack, fw_ack, busy, rd_beat, fw_beat, frame_ok;
  logic [31:0] rd_data = 0, fw_data = 0, beat_data;
  aft_pkg::aft_mode_t mode = aft_pkg::AFT_MODE_PIPE;
  int error_cnt = 0, n_tests = 0;
  aft_link_if link ();
  aft_target aft_target_i (.core_clk, .rst_n, .link(link.target), .mode, .rd_req, .rd_data,
    .fw_req, .fw_data, .frame_req, .rd_ack, .fw_ack, .busy);
  aft_master aft_master_i (.core_clk, .rst_n, .link(link.master), .rd_full, .wr_full,
    .rd_beat, .fw_beat, .frame_ok, .beat_data);
  aft_link_properties aft_link_properties_i (.core_clk, .rst_n, .rbf_n(link.rbf_n),
    .wbf_n(link.wbf_n), .st(link.st), .gnt_n(link.gnt_n), .data_valid(link.data_valid));
  always #5 core_clk = ~core_clk;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // A full flag held at the start must delay the grant; one raised mid-way must not cut it.
  task automatic xfer(input bit rd, input bit full);
    logic [31:0] d;
    int i, n;
    d = rd ? 32'hA5C3_0F01 : 32'h5A3C_F010;
    i = 0;
    n = 0;
    @(posedge core_clk);
    // a flag left low stands for a master that omits it
    rd_full <= rd & full;
    wr_full <= !rd & full;
    rd_data <= d;
    fw_data <= d;
    // The flag needs three edges to pass the master's flag register and the target's two-flop sampler.
    repeat (3) @(posedge core_clk);
    rd_req <= rd;
    fw_req <= !rd;
    while (!(rd_ack | fw_ack) && i < 30) begin
      @(posedge core_clk);
      if (i == 10) begin
        rd_full <= 1'b0;
        wr_full <= 1'b0;
      end
      #1 i++;
    end
    check(32'(i < 30), 32'h1, "ack seen");
    check(32'(i > 11), 32'(full), "held off");
    check(32'(link.st), rd ? 32'h1 : 32'h2, "status");
    check(32'(busy), 32'h1, "busy");
    @(posedge core_clk);
    rd_req <= 1'b0;
    fw_req <= 1'b0;
    rd_full <= rd;
    wr_full <= !rd;
    repeat (8) begin
      #1 if (rd ? rd_beat : fw_beat) begin
        n++;
        check(beat_data, d, "beat data");
      end
      @(posedge core_clk);
    end
    check(32'(n), 32'h4, "beats");
    #1 check(32'(busy), 32'h0, "busy after");
    @(posedge core_clk);
    rd_full <= 1'b0;
    wr_full <= 1'b0;
    repeat (5) @(posedge core_clk);
    $display("test xfer rd=%0b full=%0b done", rd, full);
  endtask
  // mode is static, so frame mode is entered through a fresh reset
  task automatic t_frame;
    @(posedge core_clk);
    rst_n <= 1'b0;
    mode <= aft_pkg::AFT_MODE_FRAME;
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    rd_full <= 1'b1;
    wr_full <= 1'b1;
    frame_req <= 1'b1;
    rd_req <= 1'b1;
    repeat (10) @(posedge core_clk);
    #1 check(32'(frame_ok), 32'h1, "frame ok");
    check(32'(link.st), 32'(aft_pkg::ST_FRAME_OK), "frame status");
    check(32'(link.data_valid), 32'h0, "no read in frame mode");
    check(32'(rd_beat), 32'h0, "no read beat in frame mode");
    @(posedge core_clk);
    frame_req <= 1'b0;
    rd_req <= 1'b0;
    $display("test frame done");
  endtask
  initial begin
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    xfer(1, 0);
    xfer(1, 1);
    xfer(0, 0);
    xfer(0, 1);
    t_frame;
    test_done;
  end
  // The tests need some 140 cycles; 2000 leaves ample margin.
  initial begin
    #20000;
    error_cnt++;
    test_done;
  end
endmodule
`default_nettype wire
